// [core/flash_host_pkg.sv]
// Notes on behaviour
// - Commands only with programming supply high; command cycle then operand cycle.
// - Erase verify: address plus code A0h in first cycle.
// - Programmer verifies every address after each erase.
// - On verify failure, repeat erase then verify; no zero prewrite needed.
// - Abort: FFh in second cycle after erase or program, FFh again third.
// - Identification codes use ordinary read-cycle strobe timing.
package flash_host_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [7:0] CMD_READ    = 8'h00;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PVERIFY = 8'hc0;
  localparam logic [7:0] CMD_ERASE   = 8'h20;
  localparam logic [7:0] CMD_EVERIFY = 8'ha0;
  localparam logic [7:0] CMD_RESET   = 8'hff;
  localparam logic [7:0] CMD_IDENT   = 8'h90;
  localparam logic [16:0] IDENT_MAKER_ADDR = 17'h00000;
  localparam logic [16:0] IDENT_DEV_ADDR   = 17'h00001;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int CLK_MHZ = 100;
  localparam int T_STROBE_NS = 150;
  localparam int T_RECOVER_US = 6;
  localparam int T_PROG_US = 10;
  localparam int T_ERASE_US = 9500;
  localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_CYC = T_RECOVER_US * CLK_MHZ;
  localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
  localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;
  localparam int CNT_W = 20;
  typedef enum logic [2:0] {
    OP_READ   = 3'b000,
    OP_PROG   = 3'b001,
    OP_ERASE  = 3'b010,
    OP_EVER   = 3'b011,
    OP_IDENT  = 3'b100,
    OP_ABORT  = 3'b101,
    OP_PVER   = 3'b110
  } op_e;
endpackage : flash_host_pkg

// [core/strobe_timer.sv]
`timescale 1ns/1ns
module strobe_timer #(
  parameter int W = 20
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] left;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      left <= '0;
    end else if (load) begin
      left <= count;
    end else if (left != '0) begin
      left <= left - 1'b1;
    end
  end
  // Done must not look at load: callers reload on done, which would close a loop
  assign done = (left == '0);
endmodule : strobe_timer

// [core/flash_host.sv]
`timescale 1ns/1ns
module flash_host
  import flash_host_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int PROG_CYCLES  = PROG_CYC,
  parameter int MEM_TOP      = 17'h1ffff
) (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         req,
  input  wire flash_host_pkg::op_e          req_op,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0] req_data,
  input  wire logic                         prog_supply_high,
  output logic                              busy,
  output logic                              done,
  output logic                              refused,
  output logic [flash_host_pkg::DATA_W-1:0] rd_data,
  output logic                              erase_clean,
  output logic [flash_host_pkg::ADDR_W-1:0] addr_pin,
  output logic [flash_host_pkg::DATA_W-1:0] data_out,
  output logic                              data_oe,
  input  wire logic [flash_host_pkg::DATA_W-1:0] data_in,
  output logic                              ce_n,
  output logic                              we_n,
  output logic                              oe_n
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SETUP = 3'b001,
    S_LOW   = 3'b010,
    S_HIGH  = 3'b011,
    S_WAIT  = 3'b100,
    S_READ  = 3'b101,
    S_SAMPLE= 3'b110,
    S_SWEEP = 3'b111
  } st_e;

  st_e st;
  op_e op;
  logic [1:0] phase;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic sweeping;
  logic t_load;
  logic [CNT_W-1:0] t_count;
  logic t_done;

  strobe_timer #(.W(CNT_W)) u_timer (
    .mclk  (mclk),
    .rst   (rst),
    .load  (t_load),
    .count (t_count),
    .done  (t_done)
  );

  // Number of write cycles for each operation before any read cycle
  function automatic logic [1:0] writes_of(input op_e o);
    case (o)
      OP_PROG, OP_ERASE: writes_of = 2'd2;
      OP_ABORT:          writes_of = 2'd3;
      OP_READ:           writes_of = 2'd1;
      default:           writes_of = 2'd1;
    endcase
  endfunction : writes_of

  // Byte put on the pins in each write cycle
  function automatic logic [DATA_W-1:0] byte_of(input op_e o, input logic [1:0] p, input logic [DATA_W-1:0] d);
    case (o)
      OP_PROG:  byte_of = (p == 2'd0) ? CMD_PROGRAM : d;
      OP_ERASE: byte_of = CMD_ERASE;
      OP_EVER:  byte_of = CMD_EVERIFY;
      OP_IDENT: byte_of = CMD_IDENT;
      OP_PVER:  byte_of = CMD_PVERIFY;
      OP_ABORT: byte_of = (p == 2'd0) ? CMD_ERASE : CMD_RESET;
      default:  byte_of = CMD_READ;
    endcase
  endfunction : byte_of

  wire last_write  = (phase + 2'd1) == writes_of(op);
  wire needs_wait  = (op == OP_PROG) || (op == OP_ERASE);
  wire erased_ok   = (data_in == ERASED_BYTE);
  wire at_top      = (addr == ADDR_W'(MEM_TOP));
  wire [CNT_W-1:0] strobe_cnt  = CNT_W'(STROBE_CYC);
  wire [CNT_W-1:0] recover_cnt = CNT_W'(RECOVER_CYC);
  wire [CNT_W-1:0] op_cnt      = (op == OP_ERASE) ? CNT_W'(ERASE_CYCLES) : CNT_W'(PROG_CYCLES);
  wire accept      = (st == S_IDLE) && req && prog_supply_high;

  always_comb begin
    t_load  = 1'b0;
    t_count = strobe_cnt;
    case (st)
      S_IDLE:   begin t_load = accept; t_count = strobe_cnt; end
      S_SETUP:  begin t_load = t_done; t_count = strobe_cnt; end
      S_LOW:    begin t_load = t_done; t_count = strobe_cnt; end
      S_HIGH:   begin t_load = t_done; t_count = (last_write && needs_wait) ? op_cnt : recover_cnt; end
      S_WAIT:   begin t_load = t_done; t_count = recover_cnt; end
      S_SWEEP:  begin t_load = 1'b1; t_count = strobe_cnt; end
      default:  begin t_load = 1'b0; t_count = strobe_cnt; end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= S_IDLE;
      op <= OP_READ;
      phase <= 2'd0;
      addr <= '0;
      wdata <= '0;
      sweeping <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      rd_data <= '0;
      erase_clean <= 1'b0;
      addr_pin <= '0;
      data_out <= '0;
      data_oe <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      refused <= 1'b0;
      case (st)
        S_IDLE: begin
          if (req && !prog_supply_high) begin
            refused <= 1'b1;
          end
          if (accept) begin
            st <= S_SETUP;
            busy <= 1'b1;
            phase <= 2'd0;
            wdata <= req_data;
            sweeping <= (req_op == OP_EVER) && (req_addr == '0);
            erase_clean <= 1'b1;
            op <= (req_op == OP_EVER && req_addr == '0) ? OP_EVER : req_op;
            addr <= req_addr;
            addr_pin <= req_addr;
            ce_n <= 1'b0;
          end
        end
        S_SETUP: if (t_done) begin
          st <= S_LOW;
          we_n <= 1'b0;
          data_oe <= 1'b1;
          data_out <= byte_of(op, phase, wdata);
        end
        S_LOW: if (t_done) begin
          st <= S_HIGH;
          we_n <= 1'b1;
        end
        S_HIGH: if (t_done) begin
          data_oe <= 1'b0;
          if (!last_write) begin
            phase <= phase + 2'd1;
            st <= S_SETUP;
          end else if (needs_wait) begin
            st <= S_WAIT;
          end else if (op == OP_ABORT) begin
            st <= S_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            ce_n <= 1'b1;
          end else begin
            st <= S_WAIT;
          end
        end
        S_WAIT: if (t_done) begin
          if (op == OP_PROG || op == OP_ERASE) begin
            st <= S_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            ce_n <= 1'b1;
          end else begin
            st <= S_READ;
            oe_n <= 1'b0;
          end
        end
        S_READ: begin
          st <= S_SAMPLE;
        end
        S_SAMPLE: if (t_done) begin
          oe_n <= 1'b1;
          rd_data <= data_in;
          if (op == OP_EVER && !erased_ok) begin
            erase_clean <= 1'b0;
          end
          if (sweeping && !at_top) begin
            st <= S_SWEEP;
          end else begin
            st <= S_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            ce_n <= 1'b1;
            sweeping <= 1'b0;
          end
        end
        S_SWEEP: begin
          // Each address needs its own command cycle in erase verify
          addr <= addr + 1'b1;
          addr_pin <= addr + 1'b1;
          phase <= 2'd0;
          st <= S_SETUP;
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  a_refuse_low: assert property (@(posedge mclk) disable iff (rst)
    (st == S_IDLE && req && !prog_supply_high) |=> refused && st == S_IDLE)
    else $error("request taken without supply high");
  a_data_stable: assert property (@(posedge mclk) disable iff (rst)
    $rose(we_n) |-> data_oe)
    else $error("data not driven at strobe rise");
  a_no_contention: assert property (@(posedge mclk) disable iff (rst)
    !(data_oe && !oe_n))
    else $error("bus contention on data pins");
  a_abort_code: assert property (@(posedge mclk) disable iff (rst)
    (op == OP_ABORT && $fell(we_n) && phase != 2'd0) |-> data_out == CMD_RESET)
    else $error("abort byte wrong");
  a_erase_code: assert property (@(posedge mclk) disable iff (rst)
    (op == OP_ERASE && $fell(we_n)) |-> data_out == CMD_ERASE)
    else $error("erase byte wrong");
  a_ident_code: assert property (@(posedge mclk) disable iff (rst)
    (op == OP_IDENT && $fell(we_n)) |-> data_out == CMD_IDENT)
    else $error("ident byte wrong");
  a_ever_code: assert property (@(posedge mclk) disable iff (rst)
    (op == OP_EVER && $fell(we_n)) |-> data_out == CMD_EVERIFY && addr_pin == addr)
    else $error("erase verify cycle wrong");
  a_read_style: assert property (@(posedge mclk) disable iff (rst)
    $fell(oe_n) |-> we_n && !ce_n && !data_oe)
    else $error("read cycle strobes wrong");
endmodule : flash_host

// [tb/flash_dev_model.sv]
`timescale 1ns/1ns
module flash_dev_model #(
  parameter logic [7:0] MAKER  = 8'h5a, // Arbitrary identity value
  parameter logic [7:0] DEVICE = 8'ha6  // Arbitrary identity value
) (
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        vpp,
  input  wire logic        stuck,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  din,
  output logic      [7:0]  dout
);
  logic [7:0]  mem [4];
  logic [7:0]  cmd  = 8'h00;
  logic [1:0]  st   = 2'h0;
  logic [16:0] wa, pa, va;
  logic [7:0]  val;
  logic [7:0]  last = 8'h00;
  wire         rd   = !ce_n && !oe_n;
  initial for (int i = 0; i < 4; i++) mem[i] = 8'h10 + 8'(i);
  always @(negedge we_n) if (!ce_n) wa = addr;
  always @(posedge we_n) if (!ce_n && vpp) begin
    if (st == 2'h2) begin
      st = 2'h0;
      if (din == 8'hff) cmd = 8'h00;
    end else if (st == 2'h1) begin
      st = 2'h0;
      if (din == 8'hff) st = 2'h2;
      else if (cmd == 8'h40) begin
        mem[wa[1:0]] = din;
        pa = wa;
      end else if (din == 8'h20) begin
        // A stuck cell stands in for an erase that did not take
        for (int i = 0; i < 4; i++) if (!(stuck && i == 2)) mem[i] = 8'hff;
      end
      if (st == 2'h0) cmd = 8'h00;
    end else begin
      cmd = din;
      if (din == 8'ha0) va = wa;
      if (din == 8'h40 || din == 8'h20) st = 2'h1;
    end
  end
  always @* case (cmd)
    8'hc0:   val = mem[pa[1:0]];
    8'ha0:   val = mem[va[1:0]];
    8'h90:   val = addr == 17'h0 ? MAKER : (addr == 17'h1 ? DEVICE : ~MAKER);
    default: val = mem[addr[1:0]];
  endcase
  // Released bus shows the inverse of the last byte, not a kept value
  always @(val or rd) if (rd) last = val;
  assign dout = rd ? val : ~last;
endmodule : flash_dev_model

// [tb/flash_host_bench.sv]
`timescale 1ns/1ns
module flash_host_bench;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary identity value
  localparam logic [7:0] DEV   = 8'ha6; // Arbitrary identity value
  logic        mclk = 0, rst = 1, req = 0, vpp = 1, stuck = 0;
  op_e         req_op = OP_READ;
  logic [16:0] req_addr = 17'h0;
  logic [7:0]  req_data = 8'h00;
  logic        busy, done, refused, erase_clean, data_oe, ce_n, we_n, oe_n;
  logic [7:0]  rd_data, data_out, dev_out;
  logic [16:0] addr_pin;
  wire  [7:0]  bus = data_oe ? data_out : dev_out;
  int          errors = 0, compares = 0;
  always #5 mclk = ~mclk;
  flash_host #(.ERASE_CYCLES(20), .PROG_CYCLES(20), .MEM_TOP(3)) u_flash_host (
    .mclk(mclk), .rst(rst), .req(req), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .prog_supply_high(vpp), .busy(busy), .done(done),
    .refused(refused), .rd_data(rd_data), .erase_clean(erase_clean), .addr_pin(addr_pin),
    .data_out(data_out), .data_oe(data_oe), .data_in(bus), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));
  flash_dev_model #(.MAKER(MAKER), .DEVICE(DEV)) u_flash_dev_model (
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .vpp(vpp), .stuck(stuck),
    .addr(addr_pin), .din(bus), .dout(dev_out));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task test_done;
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task run(input op_e o, input logic [16:0] a, input logic [7:0] d);
    int n;
    req_op = o;
    req_addr = a;
    req_data = d;
    req = 1;
    @(posedge mclk);
    #1;
    req = 0;
    n = 0;
    while (done !== 1'b1 && n < 10000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(8'(n < 10000), 8'h1);
  endtask : run
  task t_reset;
    chk(8'({ce_n, we_n, oe_n, busy}), 8'he);
  endtask : t_reset
  task t_read;
    run(OP_READ, 17'h2, 8'h00);
    chk(rd_data, 8'h12);
  endtask : t_read
  task t_program;
    run(OP_PROG, 17'h1, 8'h3c);
    run(OP_PVER, 17'h0, 8'h00);
    chk(rd_data, 8'h3c);
  endtask : t_program
  task t_abort;
    run(OP_ABORT, 17'h0, 8'h00);
    chk(u_flash_dev_model.cmd, CMD_READ);
    run(OP_READ, 17'h1, 8'h00);
    chk(rd_data, 8'h3c);
    run(OP_READ, 17'h2, 8'h00);
    chk(rd_data, 8'h12);
  endtask : t_abort
  task t_refuse;
    vpp = 0;
    req = 1;
    @(posedge mclk);
    #1;
    chk(8'({refused, busy}), 8'h2);
    req = 0;
    vpp = 1;
    @(posedge mclk);
    #1;
  endtask : t_refuse
  task t_erase;
    stuck = 1;
    run(OP_ERASE, 17'h0, 8'h00);
    run(OP_EVER, 17'h0, 8'h00);
    chk(8'(erase_clean), 8'h0);
    stuck = 0;
    run(OP_ERASE, 17'h0, 8'h00);
    run(OP_EVER, 17'h0, 8'h00);
    chk(8'(erase_clean), 8'h1);
    run(OP_READ, 17'h3, 8'h00);
    chk(rd_data, ERASED_BYTE);
  endtask : t_erase
  task t_ident;
    run(OP_IDENT, IDENT_MAKER_ADDR, 8'h00);
    chk(rd_data, MAKER);
    run(OP_IDENT, IDENT_DEV_ADDR, 8'h00);
    chk(rd_data, DEV);
  endtask : t_ident
  // Host and device never drive the data lines together
  always @(posedge mclk) if (data_oe === 1'b1 && oe_n === 1'b0) chk(8'h1, 8'h0);
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst = 0;
    t_reset();
    t_read();
    t_program();
    t_abort();
    t_refuse();
    t_erase();
    t_ident();
    test_done();
  end
  initial begin
    repeat (80000) @(posedge mclk);
    errors++;
    test_done();
  end
endmodule : flash_host_bench
